// ==== common/tsr_cfg.svh ====
// Register selections, field positions, reset values and timing counts.
// Assumes inclusion by bare name from common/.
`ifndef TSR_CFG_SVH
`define TSR_CFG_SVH
`define TSR_SEL_AMB    2'h0
`define TSR_SEL_CFG    2'h1
`define TSR_SEL_HYST   2'h2
`define TSR_SEL_LIMSET 2'h3
`define TSR_CFG_SHDN   0
`define TSR_CFG_MODE   1
`define TSR_CFG_POL    2
`define TSR_CFG_FQ_LO  3
`define TSR_CFG_RES_LO 5
`define TSR_CFG_OS     7
`define TSR_RST_SEL    2'h0
`define TSR_RST_CFG    8'h00
`define TSR_RST_HYST   16'h4b00
`define TSR_RST_LIMSET 16'h5000
`define TSR_LIM_MASK   16'hff80
`define TSR_AMB_MASK12 16'hfff0
`define TSR_CONV9_MS   30
`define TSR_CLK_KHZ    125000
`define TSR_CONV9_CYC  (`TSR_CONV9_MS * `TSR_CLK_KHZ)
`endif

// ==== common/tsr_if.sv ====
// Carrier between the register core and the conversion sequencer.
// Assumes both ends share one clock and the synchronised reset.
interface tsr_if (
    input wire logic clk,
    input wire logic rst_n
);
    logic [1:0]  res;
    logic        shutdown;
    logic        oneshot;
    logic        oneshot_clr;
    logic        tick;
    logic [15:0] ambient;
    modport conv (input clk, rst_n, res, shutdown, oneshot,
                  output oneshot_clr, tick, ambient);
    modport core (input clk, rst_n, oneshot_clr, tick, ambient,
                  output res, shutdown, oneshot);
endinterface

// ==== common/tsr_pkg.sv ====
// Types shared by the temperature sensor register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package tsr_pkg;
    typedef enum logic [1:0] {TSR_IDLE, TSR_WR, TSR_RD} tsr_phase_e;
    typedef logic [1:0] tsr_sel_t;
endpackage

// ==== rtl/tsr_conv.sv ====
// Conversion sequencer and ambient temperature result register.
// Assumes adc_code is a settled two's complement code, synchronous to clk.
`include "tsr_cfg.svh"
module tsr_conv #(
    parameter int unsigned CONV9_CYC = `TSR_CONV9_CYC,
    parameter int          CODE_W    = 12
) (
    // Core side
    tsr_if.conv                    cv,
    // Converter side
    input  wire logic [CODE_W-1:0] adc_code
);
    import tsr_pkg::*;

    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic [15:0] amb;
    logic [15:0] next_amb;
    logic        tick;
    logic        next_tick;
    logic        osc;
    logic        next_osc;
    logic        run;
    logic [31:0] limit;
    logic [15:0] mask;

    // Period doubles per extra resolution bit
    assign run   = !cv.shutdown || cv.oneshot;
    assign limit = CONV9_CYC << cv.res;
    assign mask  = 16'(`TSR_AMB_MASK12 << (2'h3 - cv.res));

    always_comb begin
        next_cnt  = cnt;
        next_amb  = amb;
        next_tick = 1'b0;
        next_osc  = 1'b0;
        if (!run) begin
            next_cnt = 32'h0;
        end else if (cnt >= limit - 32'h1) begin
            next_cnt  = 32'h0;
            // Whole word at once, so reads never see a half-updated result
            next_amb  = 16'({adc_code, 4'h0}) & mask;
            next_tick = 1'b1;
            next_osc  = cv.shutdown;
        end else begin
            next_cnt = cnt + 32'h1;
        end
    end

    always_ff @(posedge cv.clk or negedge cv.rst_n) begin
        if (!cv.rst_n) begin
            cnt  <= 32'h0;
            amb  <= 16'h0000;
            tick <= 1'b0;
            osc  <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            amb  <= next_amb;
            tick <= next_tick;
            osc  <= next_osc;
        end
    end

    assign cv.ambient     = amb;
    assign cv.tick        = tick;
    assign cv.oneshot_clr = osc;

    default clocking cb @(posedge cv.clk); endclocking
    default disable iff (!cv.rst_n);

    chk_amb_load: assert property (!$stable(amb) |-> tick)
        else $error("ambient changed without a conversion end");
    chk_amb_low: assert property (amb[3:0] == 4'h0)
        else $error("ambient low nibble not zero");
    chk_amb_res: assert property (tick |-> (amb & ~$past(mask)) == 16'h0000)
        else $error("ambient carries bits beyond resolution");
    chk_run_stop: assert property (!run |=> cnt == 32'h0 && !tick)
        else $error("conversion ran while shut down");
    cov_conv_done: cover property (tick);
    cov_oneshot:   cover property (tick && osc);
endmodule

// ==== rtl/tsr_top.sv ====
// Register bank of a serial temperature sensor with alert comparator.
// Assumes a framer that delivers matched-address frames as byte strobes.
// How it works
// - Eight-bit pointer, two low bits select
// - Selection 0..3: ambient, setup, hysteresis, limit
// - Upper pointer bits not stored, read zero
// - Ambient register is sixteen-bit, read-only
// - Ambient is two's complement, 9-12 bits
// - Ambient layout: sign, integers, fraction, zeros
// - Limit registers writable, low seven bits zero
// - Alert asserts when temperature leaves limits
// - Conversion result loaded in one parallel step
// - One refresh per conversion, 30-240 ms
// - Ambient double-buffered, reads see stable result
// - Pointer retained across later read frames
// - Setup byte: oneshot, resolution, queue, polarity, mode, shutdown
// - Resolution codes select 9-12 bits, default nine
// - Hysteresis keeps only nine top bits
`include "tsr_cfg.svh"
module tsr_top #(
    parameter int unsigned CONV9_CYC = `TSR_CONV9_CYC,
    parameter int          CODE_W    = 12
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // Byte link from the framer
    input  wire logic              frame_start,
    input  wire logic              frame_write,
    input  wire logic              rx_valid,
    input  wire logic [7:0]        rx_byte,
    input  wire logic              tx_req,
    output logic      [7:0]        tx_byte,
    // Converter
    input  wire logic [CODE_W-1:0] adc_code,
    // Open-drain alert pin
    output logic                   alert_o,
    output logic                   alert_oe
);
    import tsr_pkg::*;

    logic              rst_q1;
    logic              rst_s;
    tsr_phase_e        phase;
    tsr_phase_e        next_phase;
    logic [1:0]        idx;
    logic [1:0]        next_idx;
    tsr_pkg::tsr_sel_t sel;
    tsr_pkg::tsr_sel_t next_sel;
    logic [7:0]        cfg;
    logic [7:0]        next_cfg;
    logic [15:0]       hyst;
    logic [15:0]       next_hyst;
    logic [15:0]       limit_set_reg;
    logic [15:0]       next_limit_set_reg;
    logic [7:0]        msb;
    logic [7:0]        next_msb;
    logic [7:0]        snap;
    logic [7:0]        next_snap;
    logic [7:0]        next_tx;
    logic [2:0]        fcnt;
    logic [2:0]        next_fcnt;
    logic              hi;
    logic              next_hi;
    logic              pend;
    logic              next_pend;
    logic              next_oe;
    logic              act;
    logic              want;
    logic [2:0]        fq_len;
    logic              wr_b;
    logic              rd_b;

    // Two-stage reset release; assertion stays asynchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_q1 <= 1'b0;
            rst_s  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_s  <= rst_q1;
        end
    end

    tsr_if u_if (.clk(clk), .rst_n(rst_s));

    assign u_if.res      = cfg[`TSR_CFG_RES_LO +: 2];
    assign u_if.shutdown = cfg[`TSR_CFG_SHDN];
    assign u_if.oneshot  = cfg[`TSR_CFG_OS];

    tsr_conv #(
        .CONV9_CYC (CONV9_CYC),
        .CODE_W    (CODE_W)
    ) u_conv (
        .cv       (u_if.conv),
        .adc_code (adc_code)
    );

    assign wr_b = rx_valid && phase == TSR_WR;
    assign rd_b = tx_req && phase == TSR_RD;

    // Register access over the byte link
    always_comb begin
        next_phase = phase;
        next_idx   = idx;
        next_sel   = sel;
        next_cfg   = cfg;
        next_hyst  = hyst;
        next_limit_set_reg = limit_set_reg;
        next_msb   = msb;
        next_snap  = snap;
        next_tx    = tx_byte;
        // Hardware clear first, so a same-cycle write of the bit wins
        if (u_if.oneshot_clr) begin
            next_cfg[`TSR_CFG_OS] = 1'b0;
        end
        if (frame_start) begin
            next_phase = frame_write ? TSR_WR : TSR_RD;
            next_idx   = 2'h0;
        end else if (wr_b) begin
            next_idx = (idx == 2'h3) ? idx : idx + 2'h1;
            case (idx)
                2'h0: begin
                    next_sel = rx_byte[1:0];
                end
                2'h1: begin
                    if (sel == `TSR_SEL_CFG) begin
                        next_cfg = rx_byte;
                    end else begin
                        next_msb = rx_byte;
                    end
                end
                2'h2: begin
                    // Ambient ignores writes; limits commit with the second byte
                    if (sel == `TSR_SEL_HYST) begin
                        next_hyst = {msb, rx_byte} & `TSR_LIM_MASK;
                    end else if (sel == `TSR_SEL_LIMSET) begin
                        next_limit_set_reg = {msb, rx_byte} & `TSR_LIM_MASK;
                    end
                end
                default: begin
                end
            endcase
        end else if (rd_b) begin
            next_idx = (idx == 2'h3) ? idx : idx + 2'h1;
            case (sel)
                `TSR_SEL_AMB: begin
                    // Low byte snapshotted with the high byte to keep the pair whole
                    next_tx   = (idx == 2'h0) ? u_if.ambient[15:8] :
                                (idx == 2'h1) ? snap : 8'h00;
                    next_snap = (idx == 2'h0) ? u_if.ambient[7:0] : snap;
                end
                `TSR_SEL_CFG: next_tx = cfg;
                `TSR_SEL_HYST: begin
                    next_tx = (idx == 2'h0) ? hyst[15:8] :
                              (idx == 2'h1) ? hyst[7:0] : 8'h00;
                end
                default: begin
                    next_tx = (idx == 2'h0) ? limit_set_reg[15:8] :
                              (idx == 2'h1) ? limit_set_reg[7:0] : 8'h00;
                end
            endcase
        end
    end

    // Alert: fault queue filters, hi tracks which side was crossed
    always_comb begin
        case (cfg[`TSR_CFG_FQ_LO +: 2])
            2'h0:    fq_len = 3'h1;
            2'h1:    fq_len = 3'h2;
            2'h2:    fq_len = 3'h4;
            default: fq_len = 3'h6;
        endcase
        want = hi ? ($signed(u_if.ambient[15:7]) < $signed(hyst[15:7])) :
                    ($signed(u_if.ambient[15:7]) > $signed(limit_set_reg[15:7]));
        next_fcnt = fcnt;
        next_hi   = hi;
        next_pend = pend;
        // Interrupt pending cleared by any read byte; a new event wins
        if (rd_b) begin
            next_pend = 1'b0;
        end
        if (u_if.tick) begin
            if (!want) begin
                next_fcnt = 3'h0;
            end else if (fcnt + 3'h1 >= fq_len) begin
                next_fcnt = 3'h0;
                next_hi   = !hi;
                next_pend = 1'b1;
            end else begin
                next_fcnt = fcnt + 3'h1;
            end
        end
        act     = cfg[`TSR_CFG_MODE] ? next_pend : next_hi;
        // Pin pulled low when the asserted level is low, else when idle
        next_oe = cfg[`TSR_CFG_POL] ? !act : act;
    end

    always_ff @(posedge clk or negedge rst_s) begin
        if (!rst_s) begin
            phase    <= TSR_IDLE;
            idx      <= 2'h0;
            sel      <= `TSR_RST_SEL;
            cfg      <= `TSR_RST_CFG;
            hyst     <= `TSR_RST_HYST;
            limit_set_reg <= `TSR_RST_LIMSET;
            msb      <= 8'h00;
            snap     <= 8'h00;
            tx_byte  <= 8'h00;
            fcnt     <= 3'h0;
            hi       <= 1'b0;
            pend     <= 1'b0;
            alert_oe <= 1'b0;
            alert_o  <= 1'b0;
        end else begin
            phase    <= next_phase;
            idx      <= next_idx;
            sel      <= next_sel;
            cfg      <= next_cfg;
            hyst     <= next_hyst;
            limit_set_reg <= next_limit_set_reg;
            msb      <= next_msb;
            snap     <= next_snap;
            tx_byte  <= next_tx;
            fcnt     <= next_fcnt;
            hi       <= next_hi;
            pend     <= next_pend;
            alert_oe <= next_oe;
            alert_o  <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_s);

    chk_ptr_load: assert property (
        wr_b && !frame_start && idx == 2'h0 |=> sel == $past(rx_byte[1:0]))
        else $error("pointer not taken from low bits");
    chk_ptr_keep: assert property (!(wr_b && idx == 2'h0) |=> $stable(sel))
        else $error("pointer changed without pointer write");
    chk_cfg_read: assert property (
        rd_b && !frame_start && sel == `TSR_SEL_CFG |=> tx_byte == $past(cfg))
        else $error("setup read returned wrong byte");
    chk_cfg_write: assert property (
        wr_b && !frame_start && idx == 2'h1 && sel == `TSR_SEL_CFG |=> cfg == $past(rx_byte))
        else $error("setup write lost");
    chk_lim_low: assert property (hyst[6:0] == 7'h00 && limit_set_reg[6:0] == 7'h00)
        else $error("limit low bits not zero");
    chk_limit_commit: assert property (
        !$stable(limit_set_reg) |-> $past(wr_b && idx == 2'h2 && sel == `TSR_SEL_LIMSET))
        else $error("limit changed outside second byte");
    chk_amb_read: assert property (
        rd_b && !frame_start && sel == `TSR_SEL_AMB && idx == 2'h0 ##1 rd_b && !frame_start
        |=> {$past(tx_byte), tx_byte} == $past(u_if.ambient, 2))
        else $error("ambient pair not coherent");
    chk_alert_flip: assert property (!$stable(hi) |-> $past(u_if.tick))
        else $error("alert side changed without conversion");
    cov_lim_write: cover property (wr_b && idx == 2'h2 && sel == `TSR_SEL_HYST);
    cov_alert_on:  cover property ($rose(hi));
    cov_amb_read:  cover property (rd_b && sel == `TSR_SEL_AMB && idx == 2'h1);
endmodule

// ==== tb/tsr_master.sv ====
// Byte-link master model standing in for the serial framer and host.
// Assumes the register bank samples every strobe at posedge clk.
module tsr_master (
    // Clock and read data
    input  wire logic       clk,
    input  wire logic [7:0] tx_byte,
    // Byte link
    output logic            frame_start,
    output logic            frame_write,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            tx_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frame_start = 1'b0;
        frame_write = 1'b0;
        rx_valid    = 1'b0;
        rx_byte     = 8'h00;
        tx_req      = 1'b0;
    end
    // Pointer first; only the four selections, upper bits zero
    task automatic wr(input logic [1:0] sel, input int n, input logic [7:0] b1,
                      input logic [7:0] b2);
        int i;
        @(posedge clk);
        frame_start <= 1'b1;
        frame_write <= 1'b1;
        for (i = 0; i < n; i++) begin
            @(posedge clk);
            frame_start <= 1'b0;
            rx_valid    <= 1'b1;
            rx_byte <= (i == 0) ? {6'h00, sel} : ((i == 1) ? b1 : b2);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        // Stale byte inverted so a late sample cannot pass
        rx_byte  <= ~rx_byte;
    endtask
    task automatic rd(output logic [15:0] w);
        @(posedge clk);
        frame_start <= 1'b1;
        frame_write <= 1'b0;
        @(posedge clk);
        frame_start <= 1'b0;
        tx_req      <= 1'b1;
        // Back-to-back requests, held high across both byte edges
        @(posedge clk);
        #1 w[15:8] = tx_byte;
        @(posedge clk);
        tx_req <= 1'b0;
        #1 w[7:0] = tx_byte;
    endtask
endmodule

// ==== tb/tsr_top_tb_top.sv ====
// Self-checking bench for the register bank: reset and ambient reads, table rows, then hand tests.
// Assumes tsr_top with a short conversion count and the master model.
module tsr_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0]  sel;
        logic [1:0]  n;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [15:0] exp;
    } tsr_row_s;
    localparam tsr_row_s ROWS [8] = '{
        '{2'h2, 2'h1, 8'h00, 8'h00, 16'h4b00},
        '{2'h3, 2'h1, 8'h00, 8'h00, 16'h5000},
        '{2'h1, 2'h1, 8'h00, 8'h00, 16'h0000},
        '{2'h3, 2'h3, 8'h50, 8'h80, 16'h5080},
        '{2'h3, 2'h2, 8'h77, 8'h00, 16'h5080},
        '{2'h3, 2'h3, 8'h12, 8'hff, 16'h1280},
        '{2'h2, 2'h3, 8'h3c, 8'hff, 16'h3c80},
        '{2'h1, 2'h2, 8'h18, 8'h00, 16'h1818}
    };
    logic        clk;
    logic        rstn;
    logic        frame_start;
    logic        frame_write;
    logic        rx_valid;
    logic [7:0]  rx_byte;
    logic        tx_req;
    logic [7:0]  tx_byte;
    logic [11:0] adc_code;
    logic        alert_o;
    logic        alert_oe;
    logic [15:0] w;
    int          miscompares;
    int          checked;
    int          r;
    initial clk = 1'b0;
    always #4 clk = ~clk;
    // Short conversion count keeps the run brief
    tsr_top #(.CONV9_CYC(20), .CODE_W(12)) i_tsr_top (
        .clk(clk), .rstn(rstn), .frame_start(frame_start), .frame_write(frame_write),
        .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req), .tx_byte(tx_byte),
        .adc_code(adc_code), .alert_o(alert_o), .alert_oe(alert_oe));
    tsr_master i_tsr_master (
        .clk(clk), .tx_byte(tx_byte), .frame_start(frame_start),
        .frame_write(frame_write), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_req(tx_req));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end
    initial begin
        miscompares = 0;
        checked     = 0;
        rstn        = 1'b0;
        adc_code    = 12'h191;
        repeat (2) @(posedge clk);
        check({8'h00, tx_byte}, 16'h0000);
        check({14'h0, alert_o, alert_oe}, 16'h0000);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        i_tsr_master.rd(w);
        check(w, 16'h0000);
        repeat (30) @(posedge clk);
        i_tsr_master.rd(w);
        check(w, 16'h1900);
        i_tsr_master.wr(2'h0, 3, 8'h12, 8'h34);
        i_tsr_master.rd(w);
        check(w, 16'h1900);
        foreach (ROWS[i]) begin
            i_tsr_master.wr(ROWS[i].sel, ROWS[i].n, ROWS[i].b1, ROWS[i].b2);
            i_tsr_master.rd(w);
            check(w, ROWS[i].exp);
        end
        adc_code <= 12'hff7;
        for (r = 0; r < 4; r++) begin
            i_tsr_master.wr(2'h1, 2, {1'b0, r[1:0], 5'h00}, 8'h00);
            i_tsr_master.wr(2'h0, 1, 8'h00, 8'h00);
            // Two full conversions; the running one already ends at the new length
            repeat ((40 << r) + 20) @(posedge clk);
            i_tsr_master.rd(w);
            check(w, 16'hff70 & (16'hffff << (7 - r)));
        end
        // Hysteresis below the limit, else comparator mode toggles every conversion
        i_tsr_master.wr(2'h2, 3, 8'h10, 8'h00);
        i_tsr_master.rd(w);
        check(w, 16'h1000);
        i_tsr_master.wr(2'h1, 2, 8'h00, 8'h00);
        repeat (400) @(posedge clk);
        check({14'h0, alert_o, alert_oe}, 16'h0000);
        adc_code <= 12'h190;
        repeat (50) @(posedge clk);
        check({14'h0, alert_o, alert_oe}, 16'h0001);
        adc_code <= 12'h0f0;
        repeat (50) @(posedge clk);
        check({14'h0, alert_o, alert_oe}, 16'h0000);
        i_tsr_master.wr(2'h1, 2, 8'h01, 8'h00);
        repeat (2) @(posedge clk);
        adc_code <= 12'h7f0;
        repeat (100) @(posedge clk);
        i_tsr_master.wr(2'h0, 1, 8'h00, 8'h00);
        i_tsr_master.rd(w);
        check(w, 16'h0f00);
        i_tsr_master.wr(2'h1, 2, 8'h81, 8'h00);
        repeat (60) @(posedge clk);
        i_tsr_master.rd(w);
        check(w, 16'h0101);
        i_tsr_master.wr(2'h0, 1, 8'h00, 8'h00);
        i_tsr_master.rd(w);
        check(w, 16'h7f00);
        // Interrupt mode, active-high: pending flag drives the pin, a read clears it
        i_tsr_master.wr(2'h1, 2, 8'h06, 8'h00);
        repeat (30) @(posedge clk);
        check({14'h0, alert_o, alert_oe}, 16'h0001);
        adc_code <= 12'h0f0;
        repeat (50) @(posedge clk);
        check({14'h0, alert_o, alert_oe}, 16'h0000);
        i_tsr_master.rd(w);
        check(w, 16'h0606);
        check({14'h0, alert_o, alert_oe}, 16'h0001);
        // Reset in mid-run
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        check({6'h00, alert_o, alert_oe, tx_byte}, 16'h0000);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        i_tsr_master.rd(w);
        check(w, 16'h0000);
        final_report();
    end
endmodule
